// ### mcc_channel.sv
// Functional notes
// - On-button indicator is dark whenever the channel is off.
// - Indicator flashes red when switched on with the fader down and without program or audition routing.
// - Steady red when on and routed with the fader still down.
// - Raising the fader while armed turns the indicator green, channel live.
// - With fader already up, on presses toggle between off-dark and on-green.
// - Remote start triggers only while fader up and channel green, unless the start option is set.
// - First cue light on while first microphone selected, channel on and fader up, latched or momentary.
// - Second cue light likewise with the second microphone selected, with its own latch option.
// - Start option gives continuous momentary start from the on button.
// - Listen toggles per press; cancel option clears it when fader up and on.
// - Talkback-enable input low adds the microphone to the talkback bus.
// - Live first microphone mutes control room, studio or nothing per option.
// - Live second microphone mutes control room, studio or nothing per option.
// - Talkback source is first, second or no microphone per option.
// - Option inputs and links set behaviour; both special links flag custom logic.
// - Program routing presses are ignored while live.
// - Microphone select presses are ignored while live.
// - Channel routes to outputs only with fader open, on and a routing selected.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mcc_consts.svh"
module mcc_channel import mcc_pkg::*; #(
	parameter int unsigned DEBOUNCE_CYCLES = `MCC_DEBOUNCE_CYC,
	parameter int unsigned FLASH_CYCLES    = `MCC_FLASH_CYC
) (
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         ce,
	input  wire mcc_panel_t   panel,
	input  wire mcc_opt_t     opt,
	input  wire mcc_axi_req_t axi_req,
	output var  mcc_axi_rsp_t axi_rsp,
	output var  mcc_out_t     ctl_out
);
	typedef struct packed {
		mcc_state_t   st;
		logic         program_bus_select;
		logic         audition_bus_select;
		logic         mic2;
		logic         pfl;
		logic         flash;
		logic [27:0]  flash_cnt;
		logic [4:0]   sw_press;
		mcc_opt_t     opt_stage_a;
		mcc_opt_t     opt_stage_b;
		logic         aw_got;
		logic         w_got;
		logic [7:0]   awaddr;
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		mcc_axi_rsp_t rsp;
		mcc_out_t     out;
	} mcc_core_t;

	mcc_core_t  s_q;
	mcc_core_t  s_d;
	mcc_panel_t lvl;
	mcc_panel_t rise;

	// Every pin is synchronised and filtered; idle-high remote inputs reset to their inactive level.
	for (genvar i = 0; i < 8; i++) begin : g_db
		mcc_debounce #(
			.CYC     (DEBOUNCE_CYCLES),
			.RST_VAL (i >= 6)
		) u_db (
			.clock   (clock),
			.rstn    (rstn),
			.ce      (ce),
			.raw     (panel[i]),
			.level_q (lvl[i]),
			.rise_q  (rise[i])
		);
	end

	function automatic logic routed(input logic program_bus_select, input logic audition_bus_select);
		return program_bus_select | audition_bus_select;
	endfunction

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a[7:2] == ofs[7:2];
	endfunction

	logic       on_press;
	logic       pgm_press;
	logic       aud_press;
	logic       mic_press;
	logic       pfl_press;
	logic       fader;
	logic       live_d;
	logic       mic1_live;
	logic       mic2_live;
	mcc_opt_t   o;
	logic [31:0] rd;
	logic        rd_ok;

	always_comb begin
		s_d         = s_q;
		o           = s_q.opt_stage_b;
		fader       = lvl.fader_open;
		on_press    = rise.on_btn | s_q.sw_press[`MCC_CTRL_ON_BIT];
		pgm_press   = rise.pgm_btn | s_q.sw_press[`MCC_CTRL_PGM_BIT];
		aud_press   = rise.aud_btn | s_q.sw_press[`MCC_CTRL_AUD_BIT];
		mic_press   = rise.mic_btn | s_q.sw_press[`MCC_CTRL_MIC_BIT];
		pfl_press   = rise.pfl_btn | s_q.sw_press[`MCC_CTRL_PFL_BIT];
		s_d.opt_stage_a = opt;
		s_d.opt_stage_b = s_q.opt_stage_a;
		s_d.sw_press = 5'h0;

		if (s_q.flash_cnt >= 28'(FLASH_CYCLES - 1)) begin
			s_d.flash_cnt = 28'h0;
			s_d.flash     = !s_q.flash;
		end else begin
			s_d.flash_cnt = s_q.flash_cnt + 28'h1;
		end

		if (pgm_press && s_q.st != MCC_LIVE) begin
			s_d.program_bus_select = !s_q.program_bus_select;
		end
		if (aud_press) begin
			s_d.audition_bus_select = !s_q.audition_bus_select;
		end
		if (mic_press && s_q.st != MCC_LIVE) begin
			s_d.mic2 = !s_q.mic2;
		end

		case (s_q.st)
			MCC_OFF: begin
				if (on_press) begin
					if (fader) begin
						s_d.st = MCC_LIVE;
					end else if (routed(s_d.program_bus_select, s_d.audition_bus_select)) begin
						s_d.st = MCC_ARMED;
					end else begin
						s_d.st = MCC_UNROUTED;
					end
				end
			end
			MCC_UNROUTED: begin
				if (on_press) begin
					s_d.st = MCC_OFF;
				end else if (routed(s_d.program_bus_select, s_d.audition_bus_select)) begin
					s_d.st = MCC_ARMED;
				end
			end
			MCC_ARMED: begin
				if (on_press) begin
					s_d.st = MCC_OFF;
				end else if (!routed(s_d.program_bus_select, s_d.audition_bus_select)) begin
					s_d.st = MCC_UNROUTED;
				end else if (fader) begin
					s_d.st = MCC_LIVE;
				end
			end
			MCC_LIVE: begin
				if (on_press) begin
					s_d.st = MCC_OFF;
				end else if (!fader) begin
					s_d.st = routed(s_d.program_bus_select, s_d.audition_bus_select) ? MCC_ARMED : MCC_UNROUTED;
				end
			end
			default: begin
				s_d.st = MCC_OFF;
			end
		endcase

		// Cancel beats a press in the same cycle so a listen cannot survive the fader going up.
		live_d = (s_d.st == MCC_LIVE) && fader;
		if (o.listen_cancel_option && fader && s_d.st != MCC_OFF) begin
			s_d.pfl = 1'b0;
		end else if (pfl_press) begin
			s_d.pfl = !s_q.pfl;
		end

		mic1_live = live_d && !s_d.mic2;
		mic2_live = live_d && s_d.mic2;

		s_d.out.led_red   = (s_d.st == MCC_UNROUTED) ? s_d.flash : (s_d.st == MCC_ARMED);
		s_d.out.led_green = (s_d.st == MCC_LIVE);
		s_d.out.pgm_led   = s_d.program_bus_select;
		s_d.out.aud_led   = s_d.audition_bus_select;
		s_d.out.mic2_led  = s_d.mic2;
		s_d.out.pfl_led   = s_d.pfl;
		s_d.out.pgm_route = fader && s_d.st != MCC_OFF && s_d.program_bus_select;
		s_d.out.aud_route = fader && s_d.st != MCC_OFF && s_d.audition_bus_select;
		s_d.out.start_trigger = o.start_behaviour_option ? (lvl.on_btn && s_d.st != MCC_OFF) : live_d;
		s_d.out.cue1_light = !s_d.mic2 && fader && s_d.st != MCC_OFF
			&& (o.cue1_latch_option || lvl.on_btn);
		s_d.out.cue2_light = s_d.mic2 && fader && s_d.st != MCC_OFF
			&& (o.cue2_latch_option || lvl.on_btn);
		s_d.out.mute_control_room = (mic1_live && o.mic1_mute_select == `MCC_SEL_FIRST)
			|| (mic2_live && o.mic2_mute_select == `MCC_SEL_FIRST);
		s_d.out.mute_studio = (mic1_live && o.mic1_mute_select == `MCC_SEL_SECOND)
			|| (mic2_live && o.mic2_mute_select == `MCC_SEL_SECOND);
		s_d.out.talkback_mic1 = !lvl.talkback_en_n && o.talkback_source_select == `MCC_SEL_FIRST;
		s_d.out.talkback_mic2 = !lvl.talkback_en_n && o.talkback_source_select == `MCC_SEL_SECOND;
		s_d.out.cough_active  = !lvl.cough_n;
		s_d.out.special_logic = o.special_logic_link_a && o.special_logic_link_b;

		// Register slave: address and data are taken in either order, one write and one read at a time.
		if (axi_req.awvalid && s_q.rsp.awready) begin
			s_d.aw_got      = 1'b1;
			s_d.awaddr      = axi_req.awaddr;
			s_d.rsp.awready = 1'b0;
		end
		if (axi_req.wvalid && s_q.rsp.wready) begin
			s_d.w_got      = 1'b1;
			s_d.wdata      = axi_req.wdata;
			s_d.wstrb      = axi_req.wstrb;
			s_d.rsp.wready = 1'b0;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid) begin
			s_d.aw_got     = 1'b0;
			s_d.w_got      = 1'b0;
			s_d.rsp.bvalid = 1'b1;
			if (reg_hit(s_q.awaddr, `MCC_OFS_CTRL)) begin
				s_d.rsp.bresp = `MCC_RESP_OKAY;
				if (s_q.wstrb[0]) begin
					s_d.sw_press = s_q.wdata[4:0];
				end
			end else if (reg_hit(s_q.awaddr, `MCC_OFS_STATUS) || reg_hit(s_q.awaddr, `MCC_OFS_OPTS)) begin
				s_d.rsp.bresp = `MCC_RESP_OKAY;
			end else begin
				s_d.rsp.bresp = `MCC_RESP_SLVERR;
			end
		end
		if (s_q.rsp.bvalid && axi_req.bready) begin
			s_d.rsp.bvalid  = 1'b0;
			s_d.rsp.awready = 1'b1;
			s_d.rsp.wready  = 1'b1;
		end

		rd_ok = 1'b1;
		if (reg_hit(axi_req.araddr, `MCC_OFS_STATUS)) begin
			rd = {12'h0, 3'(s_q.st), s_q.out};
		end else if (reg_hit(axi_req.araddr, `MCC_OFS_CTRL)) begin
			rd = 32'h0;
		end else if (reg_hit(axi_req.araddr, `MCC_OFS_OPTS)) begin
			rd = {20'h0, s_q.opt_stage_b};
		end else begin
			rd    = 32'h0;
			rd_ok = 1'b0;
		end
		if (axi_req.arvalid && s_q.rsp.arready) begin
			s_d.rsp.arready = 1'b0;
			s_d.rsp.rvalid  = 1'b1;
			s_d.rsp.rdata   = rd;
			s_d.rsp.rresp   = rd_ok ? `MCC_RESP_OKAY : `MCC_RESP_SLVERR;
		end
		if (s_q.rsp.rvalid && axi_req.rready) begin
			s_d.rsp.rvalid  = 1'b0;
			s_d.rsp.arready = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_q             <= '0;
			s_q.st          <= MCC_OFF;
			s_q.rsp.awready <= 1'b1;
			s_q.rsp.wready  <= 1'b1;
			s_q.rsp.arready <= 1'b1;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign axi_rsp = s_q.rsp;
	assign ctl_out = s_q.out;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_armed_raise;
		ce && s_q.st == MCC_ARMED && fader && !on_press && routed(s_d.program_bus_select, s_d.audition_bus_select);
	endsequence

	sequence s_off_toggle;
		ce && s_q.st == MCC_OFF && fader && on_press;
	endsequence

	property p_off_dark;
		s_q.st == MCC_OFF |-> !ctl_out.led_red && !ctl_out.led_green;
	endproperty
	a_off_dark: assert property (p_off_dark) else $error("indicator lit while off");

	property p_unrouted_flash;
		s_q.st == MCC_UNROUTED |-> !ctl_out.led_green && ctl_out.led_red == s_q.flash;
	endproperty
	a_unrouted_flash: assert property (p_unrouted_flash) else $error("unrouted indicator not flashing red");

	property p_armed_red;
		s_q.st == MCC_ARMED |-> ctl_out.led_red && !ctl_out.led_green && (s_q.program_bus_select || s_q.audition_bus_select);
	endproperty
	a_armed_red: assert property (p_armed_red) else $error("armed indicator not steady red");

	property p_armed_to_live;
		s_armed_raise |=> s_q.st == MCC_LIVE && ctl_out.led_green;
	endproperty
	a_armed_to_live: assert property (p_armed_to_live) else $error("fader raise did not go live");

	property p_off_toggle;
		s_off_toggle |=> s_q.st == MCC_LIVE && ctl_out.led_green && !ctl_out.led_red;
	endproperty
	a_off_toggle: assert property (p_off_toggle) else $error("on press with fader up not green");

	// Outputs lag the filtered fader by one edge, so the fader is taken as it was when they were computed.
	property p_start_live;
		ctl_out.start_trigger && !$past(s_q.opt_stage_b.start_behaviour_option) |-> s_q.st == MCC_LIVE && $past(fader);
	endproperty
	a_start_live: assert property (p_start_live) else $error("start without live channel");

	property p_cue1;
		ctl_out.cue1_light |-> s_q.st != MCC_OFF && $past(fader) && !s_q.mic2;
	endproperty
	a_cue1: assert property (p_cue1) else $error("cue light one while off or fader down");

	property p_listen_cancel;
		ce && s_q.opt_stage_b.listen_cancel_option && fader && s_q.st == MCC_LIVE && !on_press |=> !s_q.pfl;
	endproperty
	a_listen_cancel: assert property (p_listen_cancel) else $error("listen not cancelled by fader");

	property p_pgm_locked;
		ce && s_q.st == MCC_LIVE && pgm_press |=> s_q.program_bus_select == $past(s_q.program_bus_select);
	endproperty
	a_pgm_locked: assert property (p_pgm_locked) else $error("program routing changed while live");

	property p_route;
		ctl_out.pgm_route || ctl_out.aud_route |-> $past(fader) && s_q.st != MCC_OFF && (s_q.program_bus_select || s_q.audition_bus_select);
	endproperty
	a_route: assert property (p_route) else $error("routed without fader, on or selection");
endmodule // mcc_channel
`default_nettype wire

// ### mcc_consts.svh
`ifndef MCC_CONSTS_SVH
`define MCC_CONSTS_SVH

`define MCC_CLK_NS          25
`define MCC_DEBOUNCE_NS     5000000
`define MCC_FLASH_NS        250000000
`define MCC_DEBOUNCE_CYC    ((`MCC_DEBOUNCE_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)
`define MCC_FLASH_CYC       (`MCC_FLASH_NS / `MCC_CLK_NS)

`define MCC_OFS_STATUS      8'h00
`define MCC_OFS_CTRL        8'h04
`define MCC_OFS_OPTS        8'h08

`define MCC_CTRL_ON_BIT     0
`define MCC_CTRL_PGM_BIT    1
`define MCC_CTRL_AUD_BIT    2
`define MCC_CTRL_MIC_BIT    3
`define MCC_CTRL_PFL_BIT    4

`define MCC_SEL_NONE        2'h0
`define MCC_SEL_FIRST       2'h1
`define MCC_SEL_SECOND      2'h2

`define MCC_RESP_OKAY       2'h0
`define MCC_RESP_SLVERR     2'h2

`endif

// ### mcc_pkg.sv
`default_nettype none
package mcc_pkg;

	typedef enum logic [2:0] {MCC_OFF, MCC_UNROUTED, MCC_ARMED, MCC_LIVE} mcc_state_t;

	typedef struct packed {
		logic cough_n;
		logic talkback_en_n;
		logic fader_open;
		logic on_btn;
		logic pgm_btn;
		logic aud_btn;
		logic mic_btn;
		logic pfl_btn;
	} mcc_panel_t;

	typedef struct packed {
		logic       cue1_latch_option;
		logic       cue2_latch_option;
		logic       start_behaviour_option;
		logic       listen_cancel_option;
		logic [1:0] mic1_mute_select;
		logic [1:0] mic2_mute_select;
		logic [1:0] talkback_source_select;
		logic       special_logic_link_a;
		logic       special_logic_link_b;
	} mcc_opt_t;

	typedef struct packed {
		logic led_red;
		logic led_green;
		logic pgm_led;
		logic aud_led;
		logic mic2_led;
		logic pfl_led;
		logic pgm_route;
		logic aud_route;
		logic start_trigger;
		logic cue1_light;
		logic cue2_light;
		logic mute_control_room;
		logic mute_studio;
		logic talkback_mic1;
		logic talkback_mic2;
		logic cough_active;
		logic special_logic;
	} mcc_out_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} mcc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} mcc_axi_rsp_t;

endpackage
`default_nettype wire

// ### mcc_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module mcc_debounce import mcc_pkg::*; #(
	parameter int unsigned CYC     = 200000,
	parameter logic        RST_VAL = 1'b0
) (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic raw,
	output var  logic level_q,
	output var  logic rise_q
);
	typedef struct packed {
		logic        stage_a;
		logic        stage_b;
		logic        level;
		logic        rise;
		logic [17:0] cnt;
	} mcc_db_t;

	mcc_db_t s_q;
	mcc_db_t s_d;

	// A change is accepted only after it has held for the whole window, so contact bounce never toggles twice.
	always_comb begin
		s_d      = s_q;
		s_d.stage_a = raw;
		s_d.stage_b = s_q.stage_a;
		s_d.rise    = 1'b0;
		if (s_q.stage_b == s_q.level) begin
			s_d.cnt = 18'h0;
		end else if (s_q.cnt >= 18'(CYC - 1)) begin
			s_d.cnt   = 18'h0;
			s_d.level = s_q.stage_b;
			s_d.rise  = s_q.stage_b;
		end else begin
			s_d.cnt = s_q.cnt + 18'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_q <= '{stage_a: RST_VAL, stage_b: RST_VAL, level: RST_VAL, rise: 1'b0, cnt: 18'h0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign level_q = s_q.level;
	assign rise_q  = s_q.rise;
endmodule // mcc_debounce
`default_nettype wire

// ### mcc_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// Contacts bounce once before settling, which is shorter than the debounce window.
module mcc_front_model import mcc_pkg::*; (
	input  wire logic       clock,
	input  wire mcc_panel_t want,
	output var  mcc_panel_t panel
);
	mcc_panel_t seen_q = 8'hc0;
	mcc_panel_t chg_q  = 8'h00;
	logic [1:0] left_q = 2'h0;
	always @(posedge clock) begin
		if (want !== seen_q) begin
			seen_q <= want;
			chg_q <= want ^ seen_q;
			left_q <= 2'h3;
		end else if (left_q != 2'h0) begin
			left_q <= left_q - 2'h1;
		end
		// Remote lines are made to ground while active.
		panel <= left_q[0] ? (seen_q ^ chg_q) : seen_q;
	end
endmodule // mcc_front_model
`default_nettype wire

// ### mixer_channel_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module mixer_channel_control_test import mcc_pkg::*; ();
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] mask;
		logic [1:0]  resp;
	} mcc_note_t;
	localparam logic [31:0] all_bits = 32'hffffffff;
	logic         clock = 1'b0;
	logic         rstn = 1'b0;
	logic         ce = 1'b1;
	mcc_panel_t   want = 8'hc0;
	mcc_panel_t   panel;
	mcc_opt_t     opt = 12'hc64;
	mcc_axi_req_t req = '0;
	mcc_axi_rsp_t rsp;
	mcc_out_t     ctl_out;
	mcc_out_t     ev;
	mcc_note_t    q[$];
	mcc_note_t    nt;
	logic [33:0]  sn;
	logic [31:0]  r;
	int           n_fail = 0;
	int           checked = 0;
	int           i;

	always #12.5 clock = ~clock;

	mcc_front_model mcc_front_model_i (.clock(clock), .want(want), .panel(panel));
	mcc_channel #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8)) mcc_channel_i (.clock(clock), .rstn(rstn),
		.ce(ce), .panel(panel), .opt(opt), .axi_req(req), .axi_rsp(rsp), .ctl_out(ctl_out));

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic give_up();
		n_fail++;
		$display("unexpected handshake expected answer seen none");
		wrap_up();
	endtask

	// Every answer is matched against the oldest note, so a lost or extra answer shows at once.
	always @(posedge clock) begin
		if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready)) begin
			checked++;
			if (q.size() == 0) begin
				n_fail++;
				$display("unexpected answer expected none seen %h", rsp.rdata);
			end else begin
				nt = q.pop_front();
				sn = rsp.rvalid ? {rsp.rresp, rsp.rdata & nt.mask} : {rsp.bresp, 32'h0};
				if (sn !== {nt.resp, nt.exp & nt.mask}) begin
					n_fail++;
					$display("unexpected resp_data expected %h seen %h", {nt.resp, nt.exp & nt.mask}, sn);
				end
			end
		end
	end

	task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] rs);
		int n;
		q.push_back('{e, m, rs});
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			if (rsp.arready) req.arvalid <= 1'b0;
			n++;
		end while (!rsp.rvalid && n < 100);
		if (n >= 100) give_up();
		req.rready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
		int n;
		q.push_back('{32'h0, 32'h0, rs});
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			n++;
		end while (!rsp.bvalid && n < 100);
		if (n >= 100) give_up();
		req.bready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic chk(input logic [2:0] st, input logic [16:0] e, input logic [31:0] m);
		checked++;
		if (((ctl_out ^ e) & m[16:0]) !== 17'h0) begin
			n_fail++;
			$display("unexpected ctl_out expected %h seen %h", e & m[16:0], ctl_out & m[16:0]);
		end
		axi_read(8'h00, {12'h0, st, e}, m, 2'h0);
	endtask

	// Long enough for the contact bounce, the two sync stages and the debounce count.
	task automatic settle();
		repeat (20) @(posedge clock);
	endtask

	task automatic press(input int b);
		want[b] <= 1'b1;
		settle();
		want[b] <= 1'b0;
		settle();
	endtask

	initial begin
		r = $urandom(38);
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		chk(3'h0, 17'h0, all_bits);
		axi_read(8'h08, 32'h00000c64, all_bits, 2'h0);
		axi_read(8'h0c, 32'h0, all_bits, 2'h2);
		axi_write(8'h00, 32'h0000ffff, 2'h0);
		axi_write(8'h10, 32'h0, 2'h2);
		chk(3'h0, 17'h0, all_bits);
		press(4);
		chk(3'h1, 17'h0, 32'hfffeffff);
		press(3);
		chk(3'h2, 17'h14000, all_bits);
		want.fader_open <= 1'b1;
		settle();
		chk(3'h3, 17'h0c5a0, all_bits);
		press(3);
		press(1);
		chk(3'h3, 17'h0c5a0, all_bits);
		axi_write(8'h04, 32'h4, 2'h0);
		repeat (3) @(posedge clock);
		chk(3'h3, 17'h0e7a0, all_bits);
		press(0);
		chk(3'h3, 17'h0efa0, all_bits);
		press(0);
		chk(3'h3, 17'h0e7a0, all_bits);
		for (i = 0; i < 6; i++) begin
			r = $urandom();
			want.cough_n <= r[0];
			want.talkback_en_n <= r[1];
			opt.mic1_mute_select <= r[3:2];
			opt.talkback_source_select <= r[5:4];
			opt.special_logic_link_a <= r[6];
			opt.special_logic_link_b <= r[7];
			settle();
			ev = 17'h0e7a0;
			ev.mute_control_room = (r[3:2] == 2'h1);
			ev.mute_studio = (r[3:2] == 2'h2);
			ev.talkback_mic1 = !r[1] && (r[5:4] == 2'h1);
			ev.talkback_mic2 = !r[1] && (r[5:4] == 2'h2);
			ev.cough_active = !r[0];
			ev.special_logic = r[6] && r[7];
			chk(3'h3, ev, all_bits);
		end
		want.cough_n <= 1'b1;
		want.talkback_en_n <= 1'b1;
		press(0);
		opt <= 12'hd64;
		settle();
		chk(3'h3, 17'h0e7a0, all_bits);
		press(0);
		chk(3'h3, 17'h0e7a0, all_bits);
		opt <= 12'hc64;
		press(4);
		chk(3'h0, 17'h06000, all_bits);
		press(4);
		chk(3'h3, 17'h0e7a0, all_bits);
		want.fader_open <= 1'b0;
		settle();
		chk(3'h2, 17'h16000, all_bits);
		press(1);
		chk(3'h2, 17'h17000, all_bits);
		want.fader_open <= 1'b1;
		settle();
		chk(3'h3, 17'h0f750, all_bits);
		opt <= 12'he64;
		settle();
		chk(3'h3, 17'h0f650, all_bits);
		press(4);
		opt <= 12'ha64;
		want.on_btn <= 1'b1;
		settle();
		chk(3'h3, 17'h0f750, all_bits);
		want.on_btn <= 1'b0;
		settle();
		chk(3'h3, 17'h0f610, all_bits);
		ce <= 1'b0;
		press(0);
		ce <= 1'b1;
		settle();
		chk(3'h3, 17'h0f610, all_bits);
		rstn <= 1'b0;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		chk(3'h0, 17'h0, all_bits);
		wrap_up();
	end
endmodule // mixer_channel_control_test
`default_nettype wire
